// ---- rtl/ehrp_engine.sv ----
// Emulator end of the host record protocol: command request and load/verify
`include "ehrp_consts.svh"

// Summary of operation
// - Send wait record before showing prompt.
// - Console exchanges allowed during command wait.
// - Load request header 00 or 02.
// - Verify request header 01 or 03.
// - Accepted record answered with request code F8.
// - Bad record answered with F6; host resends.
// - Interrupt code F7 stops transfer.
// - F1 from host shows prompt during command wait; during transfer it ends the transfer.
// - Symbolic text header 30..3F.
module ehrp_engine (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_header,
  input wire logic [7:0] txt_data,
  input wire logic txt_valid,
  output logic txt_ready,
  input wire logic txt_last,
  output logic cmd_busy,
  input wire logic rec_result_valid,
  input wire logic rec_result_bad,
  input wire logic xfer_abort,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] con_data,
  output logic con_valid,
  input wire logic con_ready,
  output logic prompt_pulse,
  output logic exec_pulse,
  output logic [7:0] obj_data,
  output logic obj_valid,
  output logic obj_last,
  output logic xfer_done,
  output logic xfer_aborted,
  output logic symtxt_hdr
);
  typedef struct packed {
    ehrp_pkg::ehrp_state_type state;
    ehrp_pkg::ehrp_mode_type mode;
    logic [7:0] hdr;
    logic has_txt;
    logic [1:0] rx_pos;
    logic [7:0] rx_hdr;
    logic rx_is_obj;
    logic rx_ctrl_err;
    logic [`EHRP_TXT_AW-1:0] cmd_len;
    logic [`EHRP_TXT_AW-1:0] echo_pos;
    logic [7:0] obj_data;
    logic obj_valid;
    logic obj_last;
    logic prompt;
    logic exec;
    logic done;
    logic aborted;
  } ehrp_st_type;

  ehrp_st_type st_r;
  ehrp_st_type st_nxt;
  logic [7:0] cmd_buf_r [`EHRP_TXT_DEPTH];
  logic buf_wr;
  logic [7:0] f_data;
  logic f_valid;
  logic f_ready;
  logic [7:0] hex_hi;
  logic [7:0] hex_lo;

  // Hex digit to ASCII
  function automatic logic [7:0] hex_asc(input logic [3:0] n);
    hex_asc = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_asc

  // ASCII hex digit to nibble
  function automatic logic [3:0] asc_hex(input logic [7:0] c);
    asc_hex = (c >= 8'h41) ? 4'((c - 8'h37)) : 4'((c - 8'h30));
  endfunction : asc_hex

  // Incoming bytes buffered so a console stall backs up the host link
  ehrp_fifo #(.WIDTH(`EHRP_DATA_W), .DEPTH(`EHRP_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(rx_data),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  assign hex_hi = hex_asc(st_r.hdr[7:4]);
  assign hex_lo = hex_asc(st_r.hdr[3:0]);
  assign buf_wr = (st_r.state == ehrp_pkg::ST_RX) && f_valid && (st_r.rx_pos == 2'd3)
                  && (f_data != `EHRP_CH_CR) && (st_r.rx_hdr == `EHRP_HDR_REMOTE);

  always_comb begin
    st_nxt = st_r;
    st_nxt.prompt = 1'b0;
    st_nxt.exec = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.aborted = 1'b0;
    st_nxt.obj_valid = 1'b0;
    st_nxt.obj_last = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    txt_ready = 1'b0;
    f_ready = 1'b0;
    con_data = 8'h00;
    con_valid = 1'b0;
    unique case (st_r.state)
      ehrp_pkg::ST_IDLE: begin
        if (cmd_start) begin
          // Header picks mode: F0 starts a command wait, any other header a transfer
          st_nxt.hdr = cmd_header;
          st_nxt.has_txt = 1'b1;
          st_nxt.state = ehrp_pkg::ST_TX_BSL;
          st_nxt.mode = (cmd_header == `EHRP_HDR_WAIT) ? ehrp_pkg::MD_CMD : ehrp_pkg::MD_XFER;
        end
      end
      ehrp_pkg::ST_TX_BSL: begin
        tx_data = `EHRP_CH_BSL;
        tx_valid = 1'b1;
        if (tx_ready) begin
          st_nxt.state = ehrp_pkg::ST_TX_HI;
        end
      end
      ehrp_pkg::ST_TX_HI: begin
        tx_data = hex_hi;
        tx_valid = 1'b1;
        if (tx_ready) begin
          st_nxt.state = ehrp_pkg::ST_TX_LO;
        end
      end
      ehrp_pkg::ST_TX_LO: begin
        tx_data = hex_lo;
        tx_valid = 1'b1;
        if (tx_ready) begin
          st_nxt.state = st_r.has_txt ? ehrp_pkg::ST_TX_TXT : ehrp_pkg::ST_TX_CR;
        end
      end
      ehrp_pkg::ST_TX_TXT: begin
        // Filename or prompt text; the last flag only counts with a valid byte, so at least one byte is sent
        tx_data = txt_data;
        tx_valid = txt_valid;
        txt_ready = tx_ready;
        if (txt_valid && tx_ready && txt_last) begin
          st_nxt.state = ehrp_pkg::ST_TX_CR;
        end
      end
      ehrp_pkg::ST_TX_CR: begin
        tx_data = `EHRP_CH_CR;
        tx_valid = 1'b1;
        if (tx_ready) begin
          st_nxt.state = ehrp_pkg::ST_WAIT;
          st_nxt.rx_pos = 2'd0;
          st_nxt.rx_ctrl_err = 1'b0;
          st_nxt.cmd_len = '0;
        end
      end
      ehrp_pkg::ST_WAIT: begin
        if (st_r.mode == ehrp_pkg::MD_XFER && xfer_abort) begin
          st_nxt.hdr = `EHRP_HDR_INTR;
          st_nxt.has_txt = 1'b0;
          st_nxt.state = ehrp_pkg::ST_TX_BSL;
        end else if (st_r.mode == ehrp_pkg::MD_XFER && rec_result_valid) begin
          st_nxt.hdr = rec_result_bad ? `EHRP_HDR_RETX : `EHRP_HDR_REQ;
          st_nxt.has_txt = 1'b0;
          st_nxt.state = ehrp_pkg::ST_TX_BSL;
        end else if (f_valid) begin
          st_nxt.state = ehrp_pkg::ST_RX;
        end
      end
      ehrp_pkg::ST_RX: begin
        f_ready = 1'b1;
        if (f_valid) begin
          if (f_data == `EHRP_CH_CR) begin
            // Record closed; act on what was received
            st_nxt.rx_pos = 2'd0;
            st_nxt.state = ehrp_pkg::ST_WAIT;
            if (st_r.rx_is_obj) begin
              st_nxt.obj_valid = 1'b1;
              st_nxt.obj_last = 1'b1;
              st_nxt.obj_data = st_r.rx_ctrl_err ? 8'hFF : 8'h00;
            end else if (st_r.mode == ehrp_pkg::MD_CMD && st_r.rx_hdr == `EHRP_HDR_CONIN) begin
              st_nxt.prompt = 1'b1;
              st_nxt.mode = ehrp_pkg::MD_NONE;
              st_nxt.state = ehrp_pkg::ST_IDLE;
            end else if (st_r.mode == ehrp_pkg::MD_CMD && st_r.rx_hdr == `EHRP_HDR_REMOTE) begin
              st_nxt.prompt = 1'b1;
              st_nxt.echo_pos = '0;
              st_nxt.state = ehrp_pkg::ST_ECHO;
            end else if (st_r.mode == ehrp_pkg::MD_XFER && st_r.rx_hdr == `EHRP_HDR_END) begin
              st_nxt.done = 1'b1;
              st_nxt.mode = ehrp_pkg::MD_NONE;
              st_nxt.state = ehrp_pkg::ST_IDLE;
            end else if (st_r.mode == ehrp_pkg::MD_XFER && (st_r.rx_hdr == `EHRP_HDR_INTR
                         || st_r.rx_hdr == `EHRP_HDR_REQ)) begin
              st_nxt.aborted = 1'b1;
              st_nxt.mode = ehrp_pkg::MD_NONE;
              st_nxt.state = ehrp_pkg::ST_IDLE;
            end
          end else if (st_r.rx_pos == 2'd0) begin
            st_nxt.rx_is_obj = (f_data != `EHRP_CH_BSL) && (st_r.mode == ehrp_pkg::MD_XFER);
            st_nxt.rx_pos = (f_data == `EHRP_CH_BSL) ? 2'd1 : 2'd3;
            st_nxt.obj_data = f_data;
            st_nxt.obj_valid = st_nxt.rx_is_obj;
          end else if (st_r.rx_pos == 2'd1) begin
            st_nxt.rx_hdr = {asc_hex(f_data), 4'h0};
            st_nxt.rx_pos = 2'd2;
          end else if (st_r.rx_pos == 2'd2) begin
            st_nxt.rx_hdr = {st_r.rx_hdr[7:4], asc_hex(f_data)};
            st_nxt.rx_pos = 2'd3;
          end else begin
            if (st_r.rx_is_obj) begin
              st_nxt.obj_data = f_data;
              st_nxt.obj_valid = 1'b1;
              if (f_data <= `EHRP_CH_CTRL_MAX) begin
                st_nxt.rx_ctrl_err = 1'b1;
              end
            end else if (buf_wr) begin
              st_nxt.cmd_len = st_r.cmd_len + 1'b1;
            end
          end
        end
      end
      ehrp_pkg::ST_ECHO: begin
        con_valid = 1'b1;
        con_data = cmd_buf_r[st_r.echo_pos];
        if (st_r.echo_pos == st_r.cmd_len) begin
          con_valid = 1'b0;
          st_nxt.exec = 1'b1;
          st_nxt.mode = ehrp_pkg::MD_NONE;
          st_nxt.state = ehrp_pkg::ST_IDLE;
        end else if (con_ready) begin
          st_nxt.echo_pos = st_r.echo_pos + 1'b1;
        end
      end
      default: begin
        st_nxt.state = ehrp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.state <= ehrp_pkg::ST_IDLE;
      st_r.mode <= ehrp_pkg::MD_NONE;
    end else begin
      st_r <= st_nxt;
    end
    if (buf_wr) begin
      cmd_buf_r[st_r.cmd_len] <= f_data;
    end
  end

  assign cmd_busy = (st_r.state != ehrp_pkg::ST_IDLE);
  assign prompt_pulse = st_r.prompt;
  assign exec_pulse = st_r.exec;
  assign obj_data = st_r.obj_data;
  assign obj_valid = st_r.obj_valid;
  assign obj_last = st_r.obj_last;
  assign xfer_done = st_r.done;
  assign xfer_aborted = st_r.aborted;
  assign symtxt_hdr = (st_r.rx_hdr >= `EHRP_HDR_SYMTXT_LO) && (st_r.rx_hdr <= `EHRP_HDR_SYMTXT_HI);
endmodule : ehrp_engine

// ---- rtl/ehrp_consts.svh ----
// Byte codes and sizes of the emulator-host record protocol
`ifndef EHRP_CONSTS_SVH
`define EHRP_CONSTS_SVH
`define EHRP_CH_BSL 8'h5C
`define EHRP_CH_CR 8'h0D
`define EHRP_CH_CTRL_MAX 8'h1F
`define EHRP_HDR_WAIT 8'hF0
`define EHRP_HDR_CONIN 8'hF1
`define EHRP_HDR_END 8'hF1
`define EHRP_HDR_RETX 8'hF6
`define EHRP_HDR_INTR 8'hF7
`define EHRP_HDR_REQ 8'hF8
`define EHRP_HDR_REMOTE 8'hF9
`define EHRP_HDR_LOAD_HEX 8'h00
`define EHRP_HDR_VERIFY_HEX 8'h01
`define EHRP_HDR_LOAD_S 8'h02
`define EHRP_HDR_VERIFY_S 8'h03
`define EHRP_HDR_SYMTXT_LO 8'h30
`define EHRP_HDR_SYMTXT_HI 8'h3F
`define EHRP_FIFO_DEPTH 16
`define EHRP_DATA_W 8
`define EHRP_TXT_DEPTH 64
`define EHRP_TXT_AW 6
`endif

// ---- rtl/ehrp_pkg.sv ----
// Types of the emulator-host record protocol engine
package ehrp_pkg;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_TX_BSL = 9'h002,
    ST_TX_HI = 9'h004,
    ST_TX_LO = 9'h008,
    ST_TX_TXT = 9'h010,
    ST_TX_CR = 9'h020,
    ST_WAIT = 9'h040,
    ST_RX = 9'h080,
    ST_ECHO = 9'h100
  } ehrp_state_type;

  typedef enum logic [2:0] {
    MD_NONE = 3'h1,
    MD_CMD = 3'h2,
    MD_XFER = 3'h4
  } ehrp_mode_type;
endpackage : ehrp_pkg

// ---- rtl/ehrp_fifo.sv ----
// Parameterised valid/ready FIFO for received host bytes
module ehrp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ehrp_fifo_st_type;

  ehrp_fifo_st_type st_r;
  ehrp_fifo_st_type st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data = mem_r[st_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (push) begin
      mem_r[st_r.wp] <= in_data;
    end
  end
endmodule : ehrp_fifo

// ---- test/ehrp_engine_properties.sv ----
// Port-level checks of the record protocol engine
module ehrp_engine_properties (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_start,
  input wire logic cmd_busy,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_ready,
  input wire logic prompt_pulse,
  input wire logic exec_pulse,
  input wire logic [7:0] obj_data,
  input wire logic obj_valid,
  input wire logic obj_last,
  input wire logic xfer_done,
  input wire logic xfer_aborted
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_START_BSL: assert property (cmd_start && !cmd_busy |=> cmd_busy && tx_valid && tx_data == 8'h5C)
    else $error("record did not open with a backslash");
  AST_HDR_DIGIT: assert property ($rose(tx_valid) && tx_ready ##1 tx_valid |-> tx_data inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("header digit is not upper-case hex");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("host byte changed before it was taken");
  AST_OBJ_FLAG: assert property (obj_last |-> obj_valid && (obj_data == 8'h00 || obj_data == 8'hFF))
    else $error("object record end carries a bad flag");
  AST_PROMPT_ONE: assert property (prompt_pulse |=> !prompt_pulse)
    else $error("prompt pulse longer than one cycle");
  AST_EXEC_ONE: assert property (exec_pulse |=> !exec_pulse)
    else $error("execute pulse longer than one cycle");
  AST_DONE_EXCL: assert property (xfer_done || xfer_aborted |-> !cmd_busy && !(xfer_done && xfer_aborted))
    else $error("transfer ended and aborted together");
  AST_RESET_IDLE: assert property ($fell(rst) |-> !cmd_busy && !tx_valid && rx_ready)
    else $error("engine not idle after reset");
  cover property (prompt_pulse);
  cover property (exec_pulse);
  cover property (xfer_done);
  cover property (!rx_ready);
endmodule : ehrp_engine_properties

bind ehrp_engine ehrp_engine_properties u_props (.core_clk, .rst, .cmd_start, .cmd_busy, .tx_data, .tx_valid,
  .tx_ready, .rx_ready, .prompt_pulse, .exec_pulse, .obj_data, .obj_valid, .obj_last, .xfer_done, .xfer_aborted);

// ---- test/ehrp_host_model.sv ----
// Host side model: line buffer for emulator records, byte queue towards the emulator
module ehrp_host_model (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] line_q[$];
  logic [7:0] last_q[$];
  logic [7:0] rx_q[$];
  logic tog = 1'b0;
  int n_lines = 0;
  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'hA5;
  end
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) begin
      line_q.push_back(tx_data);
      if (tx_data == 8'h0D) begin
        last_q = line_q;
        // Command handler answers a normal end; quit and symbol lines get no reply
        if (line_q.size() > 3 && line_q[1] == 8'h34 && line_q[2] == 8'h33) begin
          rx_q.push_back(8'h5C);
          rx_q.push_back(8'h46);
          rx_q.push_back(8'h38);
          rx_q.push_back(8'h0D);
        end
        line_q = {};
        n_lines++;
      end
    end
    if (rx_valid && rx_ready) rx_q.delete(0);
  end
  // Idle data line shows the inverse of its last value, never a held copy
  always @(negedge core_clk) begin
    tog <= ~tog;
    tx_ready <= !slow || tog;
    rx_valid <= rx_q.size() > 0;
    rx_data <= (rx_q.size() > 0) ? rx_q[0] : ~rx_data;
  end
endmodule : ehrp_host_model

// ---- test/testbench.sv ----
// Self-checking bench for the record protocol engine
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, cmd_start, txt_valid, txt_last, rec_result_valid, rec_result_bad, xfer_abort, con_ready, slow;
  logic [7:0] cmd_header, txt_data, tx_data, rx_data, con_data, obj_data, obj_flag;
  logic txt_ready, cmd_busy, tx_valid, tx_ready, rx_valid, rx_ready, con_valid, prompt_pulse, exec_pulse;
  logic obj_valid, obj_last, xfer_done, xfer_aborted, symtxt_hdr;
  logic [7:0] obj_q[$];
  logic [7:0] con_q[$];
  int miscompares = 0, samples_checked = 0, cycles = 0;
  int n_prompt = 0, n_exec = 0, n_done = 0, n_abort = 0, n_obj = 0, n_con = 0, n_full = 0;
  ehrp_engine u_dut (.core_clk, .rst, .cmd_start, .cmd_header, .txt_data, .txt_valid, .txt_ready, .txt_last,
    .cmd_busy, .rec_result_valid, .rec_result_bad, .xfer_abort, .tx_data, .tx_valid, .tx_ready, .rx_data,
    .rx_valid, .rx_ready, .con_data, .con_valid, .con_ready, .prompt_pulse, .exec_pulse, .obj_data, .obj_valid,
    .obj_last, .xfer_done, .xfer_aborted, .symtxt_hdr);
  ehrp_host_model u_host (.core_clk, .slow, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (prompt_pulse === 1'b1) n_prompt++;
    if (exec_pulse === 1'b1) n_exec++;
    if (xfer_done === 1'b1) n_done++;
    if (xfer_aborted === 1'b1) n_abort++;
    if (con_valid === 1'b1 && con_ready) begin
      n_con++;
      con_q.push_back(con_data);
    end
    if (rx_ready === 1'b0) n_full++;
    if (obj_valid === 1'b1 && obj_last !== 1'b1) obj_q.push_back(obj_data);
    if (obj_last === 1'b1) begin
      n_obj++;
      obj_flag = obj_data;
    end
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_cnt(ref int c, input int n);
    for (int i = 0; i < 600 && c < n; i++) @(posedge core_clk);
    check(c >= n, 16'h0001);
  endtask : wait_cnt
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction : hexc
  task automatic expect_line(input int base, input logic [7:0] h, input string s);
    logic [7:0] e[$];
    for (int i = 0; i < 600 && u_host.n_lines <= base; i++) @(posedge core_clk);
    check(u_host.n_lines > base, 16'h0001);
    e = {8'h5C, hexc(h[7:4]), hexc(h[3:0])};
    for (int i = 0; i < s.len(); i++) e.push_back(s[i]);
    e.push_back(8'h0D);
    check(16'(u_host.last_q.size()), 16'(e.size()));
    foreach (e[i]) check(u_host.last_q[i], e[i]);
  endtask : expect_line
  task automatic send_rec(input logic [7:0] h, input string s);
    int b;
    b = u_host.n_lines;
    @(negedge core_clk);
    cmd_start = 1'b1;
    cmd_header = h;
    @(negedge core_clk);
    cmd_start = 1'b0;
    for (int i = 0; i < s.len(); i++) begin
      txt_valid = 1'b1;
      txt_data = s[i];
      txt_last = (i == s.len() - 1);
      for (int k = 0; k < 200; k++) begin
        @(posedge core_clk);
        if (txt_ready === 1'b1) break;
      end
      @(negedge core_clk);
    end
    txt_valid = 1'b0;
    expect_line(b, h, s);
  endtask : send_rec
  task automatic host_send(input string s);
    @(negedge core_clk);
    for (int i = 0; i < s.len(); i++) u_host.rx_q.push_back(s[i]);
  endtask : host_send
  task automatic obj_rec(input logic ctrl);
    int o;
    string r;
    o = n_obj;
    r = ctrl ? "A\007" : ":0A";
    obj_q = {};
    host_send({r, "\r"});
    wait_cnt(n_obj, o + 1);
    check(obj_flag, ctrl ? 8'hFF : 8'h00);
    check(16'(obj_q.size()), 16'(r.len()));
    for (int i = 0; i < r.len(); i++) check(obj_q[i], r[i]);
  endtask : obj_rec
  task automatic verdict(input logic bad);
    int b;
    b = u_host.n_lines;
    @(negedge core_clk);
    rec_result_valid = 1'b1;
    rec_result_bad = bad;
    @(negedge core_clk);
    rec_result_valid = 1'b0;
    expect_line(b, bad ? 8'hF6 : 8'hF8, "");
  endtask : verdict
  task automatic t_console;
    int p;
    slow = 1'b1;
    send_rec(8'hF0, "RDY");
    slow = 1'b0;
    p = n_prompt;
    host_send("\\3FX\r");
    for (int i = 0; i < 60 && symtxt_hdr !== 1'b1; i++) @(negedge core_clk);
    check(symtxt_hdr, 16'h0001);
    host_send("\\F1\r");
    wait_cnt(n_prompt, p + 1);
    check(16'(n_prompt - p), 16'h0001);
    check(symtxt_hdr, 16'h0000);
  endtask : t_console
  task automatic t_remote;
    int e, p, c, f;
    string m;
    m = "DUMP";
    send_rec(8'hF0, "GO");
    e = n_exec;
    p = n_prompt;
    c = n_con;
    f = n_full;
    con_q = {};
    @(negedge core_clk);
    con_ready = 1'b0;
    host_send("\\F9DUMP\r");
    host_send("\\5A0123456789ABCDEFGHIJ\r");
    repeat (60) @(negedge core_clk);
    check(n_full > f, 16'h0001);
    con_ready = 1'b1;
    wait_cnt(n_exec, e + 1);
    check(16'(n_con - c), 16'h0004);
    for (int i = 0; i < m.len(); i++) check(con_q[i], m[i]);
    check(16'(n_prompt - p), 16'h0001);
    repeat (60) @(negedge core_clk);
  endtask : t_remote
  task automatic t_xfer(input logic [7:0] h, input int mode);
    int d, a, b;
    d = n_done;
    a = n_abort;
    send_rec(h, "PROG");
    if (mode == 3) host_send("\\F7\r");
    else begin
      obj_rec(mode == 2);
      if (mode == 1) verdict(1'b1);
      if (mode == 1) obj_rec(1'b0);
      verdict(1'b0);
      if (mode == 2) begin
        b = u_host.n_lines;
        @(negedge core_clk);
        xfer_abort = 1'b1;
        @(negedge core_clk);
        xfer_abort = 1'b0;
        expect_line(b, 8'hF7, "");
        host_send("\\F8\r");
      end
      else host_send("\\F1\r");
    end
    if (mode < 2) wait_cnt(n_done, d + 1);
    else wait_cnt(n_abort, a + 1);
    check(16'(n_done - d + n_abort - a), 16'h0001);
  endtask : t_xfer
  task automatic t_zcmd;
    int a;
    a = n_abort;
    send_rec(8'h43, "HE");
    wait_cnt(n_abort, a + 1);
    check(cmd_busy, 16'h0000);
  endtask : t_zcmd
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    rst = 1'b1;
    {cmd_start, txt_valid, txt_last, rec_result_valid, rec_result_bad, xfer_abort, slow} = '0;
    con_ready = 1'b1;
    cmd_header = 8'h00;
    txt_data = 8'h00;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    t_console();
    t_remote();
    t_xfer(8'h00, 0);
    t_xfer(8'h01, 1);
    t_xfer(8'h02, 2);
    t_xfer(8'h03, 3);
    t_zcmd();
    complete_run();
  end
endmodule : testbench
